// ### rtl/rsi_pkg.sv
// Constants and state layout of the reset state initializer
package rsi_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_INDIRECT  = 8'h00;
    localparam logic [7:0] IDX_TIMER     = 8'h01;
    localparam logic [7:0] IDX_PCL       = 8'h02;
    localparam logic [7:0] IDX_FLAGS     = 8'h03;
    localparam logic [7:0] IDX_FSP       = 8'h04;
    localparam logic [7:0] IDX_PORT_A    = 8'h05;
    localparam logic [7:0] IDX_PORT_B    = 8'h06;
    localparam logic [7:0] IDX_COUNTER_HIGH_LATCH    = 8'h0a;
    localparam logic [7:0] IDX_INTCTL    = 8'h0b;
    localparam logic [7:0] IDX_PIRQF     = 8'h0c;
    localparam logic [7:0] IDX_CMPCTL    = 8'h1f;
    localparam logic [7:0] IDX_OPTION    = 8'h81;
    localparam logic [7:0] IDX_DIR_A     = 8'h85;
    localparam logic [7:0] IDX_DIR_B     = 8'h86;
    localparam logic [7:0] IDX_PIRQE     = 8'h8c;
    localparam logic [7:0] IDX_PWRC      = 8'h8e;
    localparam logic [7:0] IDX_VREF      = 8'h9f;
    localparam logic [7:0] IDX_WACC      = 8'ha0;
    localparam logic [7:0] IDX_EVT_STAT  = 8'ha1;
    localparam logic [7:0] IDX_EVT_MASK  = 8'ha2;
    localparam logic [7:0] IDX_PC_VIEW   = 8'ha3;
    // Reset values and implemented-bit masks
    localparam logic [7:0]  OPTION_RST   = 8'hff;
    localparam logic [4:0]  DIR_A_RST    = 5'h1f;
    localparam logic [7:0]  DIR_B_RST    = 8'hff;
    localparam logic [12:0] PC_ZERO      = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
    localparam logic [7:0]  CMP_MASK     = 8'h3f;
    localparam logic [7:0]  VREF_MASK    = 8'hef;
    localparam logic [7:0]  PIRQ_MASK    = 8'h40;
    localparam logic [7:0]  INTC_FLAGS   = 8'h07;
    // Field positions
    localparam int FLAGS_TO  = 4;
    localparam int FLAGS_PD  = 3;
    localparam int INTC_GIE  = 7;
    localparam int PWRC_POR  = 1;
    localparam int PWRC_BO   = 0;
    // Event bit order in the event status register
    localparam int EV_POR = 0, EV_BOR = 1, EV_MRUN = 2, EV_MSLP = 3;
    localparam int EV_WRST = 4, EV_WWAKE = 5, EV_IWAKE = 6, EV_N = 7;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### rtl/rsi_top.sv
// Reset state initializer with AXI4-Lite register access
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Any reset loads the program counter with zero.
// - Core flags and power-cause flags take per-cause values.
// - Interrupt wake-up with global enable set then jumps to vector 4.
// - Wake-up sets only the interrupt flags that caused it.
// - Accumulator, timer, pointer and port data keep their contents.
// - Resets clear the low counter byte and the five-bit high latch.
// - Resets clear comparator, reference, peripheral flags and enables.
// - Unimplemented bits always read as zero.
// - Timeout and power-down flags depend on the reset or wake cause.
// - Power-on values win when power-on coincides with brown-out.
// - Power-on flag is cleared by power-on and by no other cause; software writes it.
module rsi_top
    import rsi_pkg::*;
#(
    parameter int AW = 12
) (
    input  wire logic          CLK_SYS,
    input  wire logic          RST_N,
    input  wire logic          POR_PULSE,
    input  wire logic          BOR_PULSE,
    input  wire logic          MASTER_CLEAR_PIN_RUN_PULSE,
    input  wire logic          MASTER_CLEAR_PIN_SLEEP_PULSE,
    input  wire logic          WDT_RESET_PULSE,
    input  wire logic          WDT_WAKE_PULSE,
    input  wire logic          IRQ_WAKE_PULSE,
    input  wire logic [7:0]    WAKE_INTC_SRC,
    input  wire logic [7:0]    WAKE_PIRQ_SRC,
    input  wire logic [AW-1:0] S_AXI_AWADDR,
    input  wire logic          S_AXI_AWVALID,
    output logic               S_AXI_AWREADY,
    input  wire logic [31:0]   S_AXI_WDATA,
    input  wire logic [3:0]    S_AXI_WSTRB,
    input  wire logic          S_AXI_WVALID,
    output logic               S_AXI_WREADY,
    output logic [1:0]         S_AXI_BRESP,
    output logic               S_AXI_BVALID,
    input  wire logic          S_AXI_BREADY,
    input  wire logic [AW-1:0] S_AXI_ARADDR,
    input  wire logic          S_AXI_ARVALID,
    output logic               S_AXI_ARREADY,
    output logic [31:0]        S_AXI_RDATA,
    output logic [1:0]         S_AXI_RRESP,
    output logic               S_AXI_RVALID,
    input  wire logic          S_AXI_RREADY,
    output logic [12:0]        PROG_COUNTER,
    output logic               IRQ
);
    typedef struct packed {
        logic [7:0]    wacc;
        logic [7:0]    tmr;
        logic [7:0]    fsp;
        logic [4:0]    pa;
        logic [7:0]    pb;
        logic [12:0]   pc;
        logic [4:0]    counter_high_latch;
        logic [7:0]    flags;
        logic [7:0]    intc;
        logic [7:0]    pirq;
        logic [7:0]    pie;
        logic [7:0]    cmp;
        logic [7:0]    opt;
        logic [4:0]    dira;
        logic [7:0]    dirb;
        logic [1:0]    pwrc;
        logic [7:0]    vref;
        logic          vec_pend;
        logic [EV_N-1:0] evt;
        logic [EV_N-1:0] msk;
        logic          irq;
        logic          aw_held;
        logic [7:0]    aw_idx;
        logic          w_held;
        logic [7:0]    wbyte;
        logic          wlane;
        logic          awready;
        logic          wready;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          arready;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
    } rsi_state_t;

    rsi_state_t st_ff;
    rsi_state_t nxt_st;
    logic [EV_N-1:0] ev;
    logic ev_rst;
    logic ev_wake;
    logic wr_go;

    // Read multiplexer; unimplemented bits are zero-filled
    function automatic logic [32:0] rd_mux(input rsi_state_t s,
                                           input logic [7:0] idx);
        logic [32:0] r;
        r = {1'b1, 32'h0};
        case (idx)
            IDX_INDIRECT: r[7:0] = 8'h00;
            IDX_TIMER:    r[7:0] = s.tmr;
            IDX_PCL:      r[7:0] = s.pc[7:0];
            IDX_FLAGS:    r[7:0] = s.flags;
            IDX_FSP:      r[7:0] = s.fsp;
            IDX_PORT_A:   r[4:0] = s.pa;
            IDX_PORT_B:   r[7:0] = s.pb;
            IDX_COUNTER_HIGH_LATCH:   r[4:0] = s.counter_high_latch;
            IDX_INTCTL:   r[7:0] = s.intc;
            IDX_PIRQF:    r[7:0] = s.pirq & PIRQ_MASK;
            IDX_CMPCTL:   r[7:0] = s.cmp & CMP_MASK;
            IDX_OPTION:   r[7:0] = s.opt;
            IDX_DIR_A:    r[4:0] = s.dira;
            IDX_DIR_B:    r[7:0] = s.dirb;
            IDX_PIRQE:    r[7:0] = s.pie & PIRQ_MASK;
            IDX_PWRC:     r[1:0] = s.pwrc;
            IDX_VREF:     r[7:0] = s.vref & VREF_MASK;
            IDX_WACC:     r[7:0] = s.wacc;
            IDX_EVT_STAT: r[EV_N-1:0] = s.evt;
            IDX_EVT_MASK: r[EV_N-1:0] = s.msk;
            IDX_PC_VIEW:  r[12:0] = s.pc;
            default:      r = 33'h0;
        endcase
        return r;
    endfunction

    // Cause decode with fixed priority
    always_comb begin
        ev = '0;
        if (POR_PULSE) begin
            ev[EV_POR] = 1'b1;
        end else if (BOR_PULSE) begin
            ev[EV_BOR] = 1'b1;
        end else if (MASTER_CLEAR_PIN_RUN_PULSE) begin
            ev[EV_MRUN] = 1'b1;
        end else if (MASTER_CLEAR_PIN_SLEEP_PULSE) begin
            ev[EV_MSLP] = 1'b1;
        end else if (WDT_RESET_PULSE) begin
            ev[EV_WRST] = 1'b1;
        end else if (WDT_WAKE_PULSE) begin
            ev[EV_WWAKE] = 1'b1;
        end else if (IRQ_WAKE_PULSE) begin
            ev[EV_IWAKE] = 1'b1;
        end
        ev_rst  = |ev[EV_WRST:EV_POR];
        ev_wake = ev[EV_WWAKE] | ev[EV_IWAKE];
    end

    assign wr_go = st_ff.aw_held & st_ff.w_held & ~st_ff.bvalid;

    // Next-state logic: bus access first, cause pulses override
    always_comb begin
        logic [32:0] rd;
        rd = 33'h0;
        nxt_st = st_ff;
        // Write address and data are taken in either order
        if (S_AXI_AWVALID && st_ff.awready) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.aw_idx  = S_AXI_AWADDR[9:2];
        end
        if (S_AXI_WVALID && st_ff.wready) begin
            nxt_st.w_held = 1'b1;
            nxt_st.wbyte  = S_AXI_WDATA[7:0];
            nxt_st.wlane  = S_AXI_WSTRB[0];
        end
        if (S_AXI_BVALID && S_AXI_BREADY) begin
            nxt_st.bvalid = 1'b0;
        end
        if (wr_go) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            rd = rd_mux(st_ff, st_ff.aw_idx);
            nxt_st.bresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
            if (st_ff.wlane) begin
                case (st_ff.aw_idx)
                    IDX_TIMER:  nxt_st.tmr = st_ff.wbyte;
                    IDX_PCL:    nxt_st.pc = {st_ff.counter_high_latch, st_ff.wbyte};
                    IDX_FLAGS:  nxt_st.flags = st_ff.wbyte;
                    IDX_FSP:    nxt_st.fsp = st_ff.wbyte;
                    IDX_PORT_A: nxt_st.pa = st_ff.wbyte[4:0];
                    IDX_PORT_B: nxt_st.pb = st_ff.wbyte;
                    IDX_COUNTER_HIGH_LATCH: nxt_st.counter_high_latch = st_ff.wbyte[4:0];
                    IDX_INTCTL: nxt_st.intc = st_ff.wbyte;
                    IDX_PIRQF:  nxt_st.pirq = st_ff.wbyte & PIRQ_MASK;
                    IDX_CMPCTL: nxt_st.cmp = st_ff.wbyte & CMP_MASK;
                    IDX_OPTION: nxt_st.opt = st_ff.wbyte;
                    IDX_DIR_A:  nxt_st.dira = st_ff.wbyte[4:0];
                    IDX_DIR_B:  nxt_st.dirb = st_ff.wbyte;
                    IDX_PIRQE:  nxt_st.pie = st_ff.wbyte & PIRQ_MASK;
                    IDX_PWRC:   nxt_st.pwrc = st_ff.wbyte[1:0];
                    IDX_VREF:   nxt_st.vref = st_ff.wbyte & VREF_MASK;
                    IDX_WACC:   nxt_st.wacc = st_ff.wbyte;
                    IDX_EVT_STAT:
                        nxt_st.evt = st_ff.evt & ~st_ff.wbyte[EV_N-1:0];
                    IDX_EVT_MASK: nxt_st.msk = st_ff.wbyte[EV_N-1:0];
                    default: nxt_st.tmr = st_ff.tmr;
                endcase
            end
        end
        // Read channel: one outstanding read
        if (S_AXI_RVALID && S_AXI_RREADY) begin
            nxt_st.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && st_ff.arready) begin
            rd = rd_mux(st_ff, S_AXI_ARADDR[9:2]);
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = rd[31:0];
            nxt_st.rresp  = rd[32] ? RESP_OKAY : RESP_SLVERR;
        end
        // Pending vector jump one cycle after the wake increment
        nxt_st.vec_pend = 1'b0;
        if (st_ff.vec_pend) begin
            nxt_st.pc = IRQ_VECTOR;
            nxt_st.intc[INTC_GIE] = 1'b0;
        end
        // Reset causes: contents of data registers are left alone
        if (ev_rst) begin
            nxt_st.pc     = PC_ZERO;
            nxt_st.counter_high_latch = 5'h00;
            nxt_st.opt    = OPTION_RST;
            nxt_st.dira   = DIR_A_RST;
            nxt_st.dirb   = DIR_B_RST;
            nxt_st.cmp    = 8'h00;
            nxt_st.vref   = 8'h00;
            nxt_st.pirq   = 8'h00;
            nxt_st.pie    = 8'h00;
            nxt_st.intc   = {7'h00, st_ff.intc[0]};
            nxt_st.flags[7:5] = 3'b000;
            nxt_st.vec_pend = 1'b0;
        end
        // Timeout and power-down flags by cause
        if (ev[EV_POR]) begin
            nxt_st.flags[FLAGS_TO] = 1'b1;
            nxt_st.flags[FLAGS_PD] = 1'b1;
            nxt_st.pwrc[PWRC_POR]  = 1'b0;
        end
        if (ev[EV_BOR]) begin
            nxt_st.flags[FLAGS_TO] = 1'b1;
            nxt_st.flags[FLAGS_PD] = 1'b1;
            nxt_st.pwrc[PWRC_BO]   = 1'b0;
        end
        if (ev[EV_MSLP]) begin
            nxt_st.flags[FLAGS_TO] = 1'b1;
            nxt_st.flags[FLAGS_PD] = 1'b0;
        end
        if (ev[EV_WRST]) begin
            nxt_st.flags[FLAGS_TO] = 1'b0;
            nxt_st.flags[FLAGS_PD] = 1'b1;
        end
        // Wake-ups resume at the next address
        if (ev_wake) begin
            nxt_st.pc = st_ff.pc + 13'h0001;
            nxt_st.flags[FLAGS_PD] = 1'b0;
            nxt_st.flags[FLAGS_TO] = ev[EV_IWAKE];
        end
        if (ev[EV_IWAKE]) begin
            nxt_st.intc = st_ff.intc | (WAKE_INTC_SRC & INTC_FLAGS);
            nxt_st.pirq = (st_ff.pirq | WAKE_PIRQ_SRC) & PIRQ_MASK;
            nxt_st.vec_pend = st_ff.intc[INTC_GIE];
        end
        // Sticky events: set wins over a software clear
        nxt_st.evt = nxt_st.evt | ev;
        nxt_st.irq = |(nxt_st.evt & nxt_st.msk);
        nxt_st.awready = ~nxt_st.aw_held & ~nxt_st.bvalid;
        nxt_st.wready  = ~nxt_st.w_held & ~nxt_st.bvalid;
        nxt_st.arready = ~nxt_st.rvalid;
    end

    // State register
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign S_AXI_AWREADY = st_ff.awready;
    assign S_AXI_WREADY  = st_ff.wready;
    assign S_AXI_BVALID  = st_ff.bvalid;
    assign S_AXI_BRESP   = st_ff.bresp;
    assign S_AXI_ARREADY = st_ff.arready;
    assign S_AXI_RVALID  = st_ff.rvalid;
    assign S_AXI_RDATA   = st_ff.rdata;
    assign S_AXI_RRESP   = st_ff.rresp;
    assign PROG_COUNTER  = st_ff.pc;
    assign IRQ           = st_ff.irq;

    // Checks on the cause handling
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    sequence s_irq_wake_gie;
        ev[EV_IWAKE] && st_ff.intc[INTC_GIE];
    endsequence
    sequence s_vector_after_step;
        st_ff.vec_pend ##1 ((st_ff.pc == IRQ_VECTOR) && !st_ff.intc[INTC_GIE]);
    endsequence
    property p_reset_pc;
        ev_rst |=> (st_ff.pc == PC_ZERO) && (st_ff.counter_high_latch == 5'h00);
    endproperty
    a_reset_pc: assert property (p_reset_pc)
        else $error("Program counter not cleared by reset");
    property p_wake_step;
        ev_wake && !st_ff.vec_pend |=>
            st_ff.pc == ($past(st_ff.pc) + 13'h0001);
    endproperty
    a_wake_step: assert property (p_wake_step)
        else $error("Wake-up did not advance the program counter");
    property p_vector_seq;
        s_irq_wake_gie ##1 (!ev_rst && !ev_wake) |-> s_vector_after_step;
    endproperty
    a_vector_seq: assert property (p_vector_seq)
        else $error("Interrupt wake did not reach the vector");
    property p_por_flags;
        ev[EV_POR] |=> st_ff.flags[FLAGS_TO] && st_ff.flags[FLAGS_PD]
            && !st_ff.pwrc[PWRC_POR] && st_ff.evt[EV_POR];
    endproperty
    a_por_flags: assert property (p_por_flags)
        else $error("Power-on flag values wrong");
    property p_cause_flags;
        (ev[EV_WRST] |=> st_ff.flags[4:3] == 2'b01) and
        (ev[EV_MSLP] |=> st_ff.flags[4:3] == 2'b10) and
        (ev[EV_WWAKE] |=> st_ff.flags[4:3] == 2'b00);
    endproperty
    a_cause_flags: assert property (p_cause_flags)
        else $error("Timeout or power-down flag wrong for cause");
    property p_keep_data;
        (ev_rst || ev_wake) && !wr_go |=>
            $stable(st_ff.wacc) && $stable(st_ff.tmr) && $stable(st_ff.fsp);
    endproperty
    a_keep_data: assert property (p_keep_data)
        else $error("Data register changed by reset or wake");
    property p_dirs;
        ev_rst |=> st_ff.opt == OPTION_RST && st_ff.dirb == DIR_B_RST
            && st_ff.dira == DIR_A_RST;
    endproperty
    a_dirs: assert property (p_dirs)
        else $error("Option or direction not set by reset");
    property p_clears;
        ev_rst |=> st_ff.cmp == 8'h00 && st_ff.vref == 8'h00
            && st_ff.pie == 8'h00 && st_ff.intc[7:1] == 7'h00;
    endproperty
    a_clears: assert property (p_clears)
        else $error("Control registers not cleared by reset");
    property p_wake_flags;
        ev[EV_IWAKE] && !wr_go && !st_ff.vec_pend |=> st_ff.intc ==
            ($past(st_ff.intc) | ($past(WAKE_INTC_SRC) & INTC_FLAGS));
    endproperty
    a_wake_flags: assert property (p_wake_flags)
        else $error("Wake changed unrelated interrupt flags");
    property p_por_first;
        POR_PULSE && BOR_PULSE |=> !st_ff.evt[EV_BOR] ||
            $past(st_ff.evt[EV_BOR]);
    endproperty
    a_por_first: assert property (p_por_first)
        else $error("Brown-out taken while power-on present");
    property p_por_only;
        !ev[EV_POR] && !wr_go |=> st_ff.pwrc[PWRC_POR] ==
            $past(st_ff.pwrc[PWRC_POR]);
    endproperty
    a_por_only: assert property (p_por_only)
        else $error("Power-on flag changed by other cause");
endmodule

// ### verification/test_reset_state_initializer.sv
// Self-checking testbench of the reset state initializer
`timescale 1ns/1ps
module test_reset_state_initializer;
    import rsi_pkg::*;
    logic        clk_sys, rst_n;
    logic [6:0]  cause;
    logic [7:0]  intc_src, pirq_src;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq;
    logic [12:0] pc;
    int          n_mismatch, n_checks;
    // Registers cleaned by each reset: index, write, read-back, reset value
    localparam logic [7:0] RIDX [9] = '{IDX_PCL, IDX_COUNTER_HIGH_LATCH, IDX_CMPCTL,
        IDX_VREF, IDX_PIRQF, IDX_PIRQE, IDX_OPTION, IDX_DIR_A, IDX_DIR_B};
    localparam logic [7:0] RWR [9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] RBK [9] = '{8'hff, 8'h1f, 8'h3f, 8'hef, 8'h40,
        8'h40, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] RRST [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hff, 8'h1f, 8'hff};
    // Registers that keep their contents, with the values kept
    localparam logic [7:0] KIDX [5] = '{IDX_WACC, IDX_TIMER, IDX_FSP,
        IDX_PORT_A, IDX_PORT_B};
    localparam logic [7:0] KVAL [5] = '{8'h5a, 8'ha5, 8'h3c, 8'h15, 8'hc3};
    // Reset causes in turn, with flags and power-cause values expected
    localparam logic [6:0] RC [5] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10};
    localparam logic [7:0] RFL [5] = '{8'h18, 8'h18, 8'h18, 8'h10, 8'h08};
    localparam logic [7:0] RPW [5] = '{8'h01, 8'h02, 8'h03, 8'h03, 8'h03};

    rsi_top #(.AW(12)) DUT (
        .CLK_SYS(clk_sys), .RST_N(rst_n),
        .POR_PULSE(cause[EV_POR]), .BOR_PULSE(cause[EV_BOR]),
        .MASTER_CLEAR_PIN_RUN_PULSE(cause[EV_MRUN]), .MASTER_CLEAR_PIN_SLEEP_PULSE(cause[EV_MSLP]),
        .WDT_RESET_PULSE(cause[EV_WRST]), .WDT_WAKE_PULSE(cause[EV_WWAKE]),
        .IRQ_WAKE_PULSE(cause[EV_IWAKE]),
        .WAKE_INTC_SRC(intc_src), .WAKE_PIRQ_SRC(pirq_src),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .PROG_COUNTER(pc), .IRQ(irq));

    // Clock at 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task test_done();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Register write, response code checked
    task wr(input logic [7:0] idx, input logic [7:0] d,
            input logic [1:0] er = RESP_OKAY);
        logic aw_p, w_p, b_p;
        aw_p = 1'b1;
        w_p  = 1'b1;
        b_p  = 1'b1;
        @(posedge clk_sys);
        awaddr  <= {2'b00, idx, 2'b00};
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int i = 0; i < 40 && b_p; i++) begin
            @(posedge clk_sys);
            if (!aw_p && !w_p && bvalid) begin
                b_p = 1'b0;
                bready <= 1'b0;
                chk({30'h0, bresp}, {30'h0, er});
            end
            if (aw_p && awready) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end
        if (b_p) chk(32'h1, 32'h0);
    endtask

    // Register read, data and response code checked
    task rd_chk(input logic [7:0] idx, input logic [31:0] exp,
                input logic [1:0] er = RESP_OKAY);
        logic r_p;
        r_p = 1'b1;
        @(posedge clk_sys);
        araddr  <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int i = 0; i < 40 && r_p; i++) begin
            @(posedge clk_sys);
            if (!arvalid && rvalid) begin
                r_p = 1'b0;
                rready <= 1'b0;
                chk(rdata, exp);
                chk({30'h0, rresp}, {30'h0, er});
            end
            if (arvalid && arready) arvalid <= 1'b0;
        end
        if (r_p) chk(32'h1, 32'h0);
    endtask

    // One-cycle cause pulse; returns just after the edge that takes it
    task pulse(input logic [6:0] m, input logic [7:0] isrc = 8'h00,
               input logic [7:0] psrc = 8'h00);
        @(posedge clk_sys);
        cause    <= m;
        intc_src <= isrc;
        pirq_src <= psrc;
        @(posedge clk_sys);
        cause    <= 7'h00;
        intc_src <= 8'h00;
        pirq_src <= 8'h00;
        #1;
    endtask

    // Every reset cause against dirtied registers
    task t_resets();
        for (int k = 0; k < 5; k++) wr(KIDX[k], KVAL[k]);
        for (int c = 0; c < 5; c++) begin
            for (int j = 0; j < 9; j++) begin
                wr(RIDX[j], RWR[j]);
                if (c == 0) rd_chk(RIDX[j], {24'h0, RBK[j]});
            end
            wr(IDX_PWRC, 8'h03);
            wr(IDX_INTCTL, 8'hff);
            wr(IDX_EVT_STAT, 8'h7f);
            pulse(RC[c]);
            chk({19'h0, pc}, {19'h0, PC_ZERO});
            for (int j = 0; j < 9; j++)
                rd_chk(RIDX[j], {24'h0, RRST[j]});
            rd_chk(IDX_FLAGS, {24'h0, RFL[c]});
            rd_chk(IDX_PWRC, {24'h0, RPW[c]});
            rd_chk(IDX_INTCTL, 32'h1);
            rd_chk(IDX_EVT_STAT, {25'h0, RC[c]});
            for (int k = 0; k < 5 && c > 0; k++)
                rd_chk(KIDX[k], {24'h0, KVAL[k]});
        end
    endtask

    // Watchdog and interrupt wake-ups, with and without global enable
    task t_wakes();
        wr(IDX_INTCTL, 8'h00);
        wr(IDX_PIRQF, 8'h00);
        wr(IDX_OPTION, 8'h00);
        wr(IDX_COUNTER_HIGH_LATCH, 8'h01);
        wr(IDX_PCL, 8'h20);
        pulse(7'h20);
        chk({19'h0, pc}, 32'h121);
        rd_chk(IDX_OPTION, 32'h0);
        rd_chk(IDX_FLAGS, 32'h00);
        pulse(7'h40, 8'h04, 8'h40);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({19'h0, pc}, 32'h122);
        rd_chk(IDX_INTCTL, 32'h04);
        rd_chk(IDX_PIRQF, 32'h40);
        rd_chk(IDX_FLAGS, 32'h10);
        wr(IDX_INTCTL, 8'h84);
        pulse(7'h40, 8'h01);
        chk({19'h0, pc}, 32'h123);
        @(posedge clk_sys);
        #1;
        chk({19'h0, pc}, {19'h0, IRQ_VECTOR});
        rd_chk(IDX_INTCTL, 32'h05);
        rd_chk(IDX_PIRQF, 32'h40);
        rd_chk(IDX_PC_VIEW, 32'h4);
        for (int k = 0; k < 5; k++) rd_chk(KIDX[k], {24'h0, KVAL[k]});
    endtask

    // Event mask, interrupt line, priority and refused accesses
    task t_events();
        wr(IDX_EVT_STAT, 8'h7f);
        wr(IDX_EVT_MASK, 8'h10);
        pulse(7'h04);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({31'h0, irq}, 32'h0);
        pulse(7'h10);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({31'h0, irq}, 32'h1);
        rd_chk(IDX_EVT_STAT, 32'h14);
        wr(IDX_EVT_STAT, 8'h10);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({31'h0, irq}, 32'h0);
        rd_chk(IDX_EVT_STAT, 32'h04);
        wr(IDX_EVT_STAT, 8'h7f);
        wr(IDX_PWRC, 8'h03);
        pulse(7'h03);
        rd_chk(IDX_EVT_STAT, 32'h01);
        rd_chk(IDX_PWRC, 32'h01);
        rd_chk(IDX_FLAGS, 32'h18);
        wr(IDX_PCL, 8'h33);
        pulse(7'h30);
        chk({19'h0, pc}, 32'h0);
        rd_chk(IDX_FLAGS, 32'h08);
        wr(8'h50, 8'hff, RESP_SLVERR);
        rd_chk(8'h50, 32'h0, RESP_SLVERR);
        rd_chk(IDX_INDIRECT, 32'h0);
        // A write without byte lane 0 must leave the register alone
        wstrb <= 4'h0;
        wr(IDX_WACC, 8'hff);
        wstrb <= 4'h1;
        rd_chk(IDX_WACC, 32'h5a);
    endtask

    // Watchdog against a hang
    initial begin
        #3000000;
        n_mismatch++;
        test_done();
    end

    // Main sequence: reset for six cycles, then the scenarios
    initial begin
        n_mismatch = 0;
        n_checks = 0;
        rst_n = 1'b0;
        cause = 7'h00;
        intc_src = 8'h00;
        pirq_src = 8'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        wstrb = 4'h1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_resets();
        t_wakes();
        t_events();
        test_done();
    end
endmodule
